/* File: verilog/sflash_read_map.svh */
// Opcodes, address layout, reset values and timing figures of the read block
`ifndef SFLASH_READ_MAP_SVH
`define SFLASH_READ_MAP_SVH

// Read opcodes
`define OP_READ_LEGACY 8'hE8
`define OP_READ_FAST 8'h0B
`define OP_READ_SLOW 8'h03
`define OP_READ_PAGE 8'hD2

// Bit counts per phase, as last index counting down to zero
`define OPCODE_LAST_BIT 6'h07
`define ADDR_LAST_BIT 6'h17
`define DUMMY_ONE_LAST_BIT 6'h07
`define DUMMY_FOUR_LAST_BIT 6'h1F
`define BYTE_LAST_BIT 3'h7

// Main-memory address layout, 264-byte pages
`define STD_PAGE_MSB 17
`define STD_PAGE_LSB 9
`define STD_BYTE_MSB 8
// Main-memory address layout, 256-byte pages
`define BIN_PAGE_MSB 16
`define BIN_PAGE_LSB 8
`define BIN_BYTE_MSB 7
// Last byte of a page in each layout
`define STD_PAGE_LAST_BYTE 9'h107
`define BIN_PAGE_LAST_BYTE 9'h0FF

// Prefetch buffer shape
`define BYTE_W 8
`define FIFO_DEPTH 32

// Synchroniser reset: chip select idles high, all else low
`define SYNC_RESET 4'h8

// Clock figures in MHz
`define SYS_CLK_MHZ 50
`define FAST_READ_CLOCK_LIMIT_MHZ 66
`define SLOW_READ_CLOCK_LIMIT_MHZ 33

`endif

/* File: verilog/sflash_read_pkg.sv */
// Types shared by the serial flash read block
package sflash_read_pkg;

   // Link sequencer states, Gray coded along idle-opcode-address-dummy-data
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_OPCODE = 3'h1,
      ST_ADDR = 3'h3,
      ST_DUMMY = 3'h2,
      ST_DATA = 3'h6,
      ST_SKIP = 3'h7
   } link_state_e;

   typedef logic [8:0] page_t;
   typedef logic [8:0] byte_t;

endpackage : sflash_read_pkg

/* File: verilog/stream_if.sv */
// Valid/ready byte stream between the read sequencer and its prefetch buffer
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : stream_if

/* File: verilog/byte_fifo.sv */
// Synchronous FIFO with flush, valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk, // Clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic flush, // Drops all stored words
   stream_if.snk in_s, // Filling side
   stream_if.src out_s // Draining side
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [AW:0] count_r, count_nxt;
   logic push;
   logic pop;

   // Honest flags from the occupancy count, with ready also masked by flush
   assign in_s.ready = (count_r != (AW+1)'(DEPTH)) && !flush;
   assign out_s.valid = (count_r != '0);
   assign out_s.data = mem[rd_ptr_r];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready && !flush;

   // Pointer and count update; flush beats both sides
   always_comb begin
      wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_nxt = (AW+1)'(count_r + {AW'(0), push} - {AW'(0), pop});
      if (flush) begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         count_nxt = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_s.data;
      end
   end
endmodule : byte_fifo

/* File: verilog/sflash_read.sv */
// Serial flash main-memory read sequencer with prefetch buffer
`timescale 1ns/1ps
`include "sflash_read_map.svh"

module sflash_read (
   input wire logic sys_clk, // System clock, 50 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic chip_select_n, // Host chip select, active low
   input wire logic serial_clk, // Host serial clock
   input wire logic serial_in, // Host serial data to device
   output logic serial_out, // Serial data to host
   output logic serial_out_oe, // Serial output driven while high
   input wire logic page_size_bin, // High selects 256-byte page layout
   output logic mem_rd_en, // One-cycle array read strobe
   output sflash_read_pkg::page_t mem_page, // Array page of the read
   output sflash_read_pkg::byte_t mem_byte, // Byte within that page
   input wire logic [7:0] mem_rd_data // Array byte, one cycle after strobe
);

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************

   logic [3:0] sync1_r, sync1_nxt;
   logic [3:0] sync2_r, sync2_nxt;
   logic [1:0] prev_r, prev_nxt;
   logic cs_n_s;
   logic sck_s;
   logic si_s;
   logic bin_s;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;

   // The host pins move with no relation to sys_clk, so each one is
   // retimed before use. Sampling all four through the same depth keeps
   // data and clock in step: a bit on serial_in is always seen in the
   // same cycle as the serial clock edge that qualifies it.
   // Two stages for every pin; only the second stage is looked at
   always_comb begin
      sync1_nxt = {chip_select_n, serial_clk, serial_in, page_size_bin};
      sync2_nxt = sync1_r;
      prev_nxt = {sync2_r[3], sync2_r[2]};
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= `SYNC_RESET;
         sync2_r <= `SYNC_RESET;
         prev_r <= 2'h2;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign cs_n_s = sync2_r[3];
   assign sck_s = sync2_r[2];
   assign si_s = sync2_r[1];
   assign bin_s = sync2_r[0];

   // The previous-value register resets to select high and clock low. In
   // mode 3 this shows a false rise once the clock is raised, but that
   // happens with select high and the idle state ignores it.
   // Edges of the sampled serial clock; idle level does not matter
   assign sck_rise = sck_s && !prev_r[0];
   assign sck_fall = !sck_s && prev_r[0];
   assign cs_fall = prev_r[1] && !cs_n_s;

   // ****************************************************************
   // Prefetch buffer
   // ****************************************************************

   // The buffer hides the array latency from the link. The sequencer only
   // takes a byte when a new one is due on the serial output, and the
   // fetch side keeps refilling while there is room, so a page or array
   // crossing costs no extra serial clocks.
   stream_if #(.WIDTH(`BYTE_W)) fill_s ();
   stream_if #(.WIDTH(`BYTE_W)) drain_s ();
   logic flush;

   byte_fifo #(
      .WIDTH(`BYTE_W),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .rst(rst),
      .flush(flush),
      .in_s(fill_s),
      .out_s(drain_s)
   );

   // ****************************************************************
   // Link sequencer
   // ****************************************************************

   sflash_read_pkg::link_state_e state_r, state_nxt;
   logic [5:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] opcode_r, opcode_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic [7:0] out_r, out_nxt;
   logic [2:0] out_cnt_r, out_cnt_nxt;
   logic so_r, so_nxt;
   logic start;
   logic pop;
   logic [7:0] op_in;
   logic [23:0] addr_in;

   // Bits assembled MSB first from the sampled input
   assign op_in = {opcode_r[6:0], si_s};
   assign addr_in = {addr_r[22:0], si_s};

   // Limitation: every serial clock level must last at least four sys_clk
   // cycles, since each edge is found by oversampling. The fast and slow
   // read clock limits of the real link are far above what this block
   // can follow; they are kept as constants only.
   // Command parsing on rising edges, data shifting on falling edges
   always_comb begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      opcode_nxt = opcode_r;
      addr_nxt = addr_r;
      out_nxt = out_r;
      out_cnt_nxt = out_cnt_r;
      so_nxt = so_r;
      start = 1'b0;
      pop = 1'b0;
      if (cs_n_s) begin
         state_nxt = sflash_read_pkg::ST_IDLE;
         out_cnt_nxt = 3'h0;
      end else begin
         unique case (state_r)
            sflash_read_pkg::ST_IDLE: begin
               // Only a real falling edge of chip select opens a command
               if (cs_fall) begin
                  state_nxt = sflash_read_pkg::ST_OPCODE;
                  bit_cnt_nxt = `OPCODE_LAST_BIT;
               end
            end
            sflash_read_pkg::ST_OPCODE: begin
               if (sck_rise) begin
                  opcode_nxt = op_in;
                  bit_cnt_nxt = bit_cnt_r - 6'h01;
                  if (bit_cnt_r == 6'h00) begin
                     bit_cnt_nxt = `ADDR_LAST_BIT;
                     // Commands other than the four reads are ignored here
                     if (op_in == `OP_READ_LEGACY || op_in == `OP_READ_FAST ||
                         op_in == `OP_READ_SLOW || op_in == `OP_READ_PAGE) begin
                        state_nxt = sflash_read_pkg::ST_ADDR;
                     end else begin
                        state_nxt = sflash_read_pkg::ST_SKIP;
                     end
                  end
               end
            end
            sflash_read_pkg::ST_ADDR: begin
               if (sck_rise) begin
                  addr_nxt = addr_in;
                  bit_cnt_nxt = bit_cnt_r - 6'h01;
                  if (bit_cnt_r == 6'h00) begin
                     // Load the counter now so prefetch overlaps dummy bytes
                     start = 1'b1;
                     if (opcode_r == `OP_READ_SLOW) begin
                        state_nxt = sflash_read_pkg::ST_DATA;
                     end else if (opcode_r == `OP_READ_FAST) begin
                        state_nxt = sflash_read_pkg::ST_DUMMY;
                        bit_cnt_nxt = `DUMMY_ONE_LAST_BIT;
                     end else begin
                        state_nxt = sflash_read_pkg::ST_DUMMY;
                        bit_cnt_nxt = `DUMMY_FOUR_LAST_BIT;
                     end
                  end
               end
            end
            sflash_read_pkg::ST_DUMMY: begin
               if (sck_rise) begin
                  bit_cnt_nxt = bit_cnt_r - 6'h01;
                  if (bit_cnt_r == 6'h00) begin
                     state_nxt = sflash_read_pkg::ST_DATA;
                  end
               end
            end
            sflash_read_pkg::ST_DATA: begin
               // New bit after each falling edge so the host samples on rising
               if (sck_fall) begin
                  if (out_cnt_r == 3'h0) begin
                     // An empty buffer holds the line rather than send junk
                     if (drain_s.valid) begin
                        pop = 1'b1;
                        so_nxt = drain_s.data[7];
                        out_nxt = {drain_s.data[6:0], 1'b0};
                        out_cnt_nxt = `BYTE_LAST_BIT;
                     end
                  end else begin
                     so_nxt = out_r[7];
                     out_nxt = {out_r[6:0], 1'b0};
                     out_cnt_nxt = out_cnt_r - 3'h1;
                  end
               end
            end
            sflash_read_pkg::ST_SKIP: begin
               // Unsupported command: wait for chip select to rise
               state_nxt = sflash_read_pkg::ST_SKIP;
            end
            default: begin
               state_nxt = sflash_read_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= sflash_read_pkg::ST_IDLE;
         bit_cnt_r <= 6'h00;
         opcode_r <= 8'h00;
         addr_r <= 24'h000000;
         out_r <= 8'h00;
         out_cnt_r <= 3'h0;
         so_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         opcode_r <= opcode_nxt;
         addr_r <= addr_nxt;
         out_r <= out_nxt;
         out_cnt_r <= out_cnt_nxt;
         so_r <= so_nxt;
      end
   end

   // The enable follows the synchronised select, so it drops one to two
   // sys_clk cycles after the pin rises; the serial output itself keeps
   // its last bit, since only the enable tells the pad to float.
   // Output floats outside the data phase and as soon as the synchronised select rises
   assign serial_out = so_r;
   assign serial_out_oe = (state_r == sflash_read_pkg::ST_DATA) && !cs_n_s;
   assign drain_s.ready = pop;

   // ****************************************************************
   // Array address counter and fetch
   // ****************************************************************

   sflash_read_pkg::page_t page_r, page_nxt;
   sflash_read_pkg::byte_t byte_r, byte_nxt;
   logic on_r, on_nxt;
   logic pend_r, pend_nxt;
   logic bin_r, bin_nxt;
   logic page_mode_r, page_mode_nxt;
   sflash_read_pkg::byte_t last_byte;

   // Only one array read is ever in flight. This halves the fetch rate,
   // but the free-slot test stays exact without a credit counter, and one
   // byte every two cycles is still far ahead of the link.
   // A new command or a deselect discards any prefetched bytes
   assign flush = start || cs_n_s;
   assign last_byte = bin_r ? `BIN_PAGE_LAST_BYTE : `STD_PAGE_LAST_BYTE;

   // Start address decode, then one array read per free buffer slot
   always_comb begin
      page_nxt = page_r;
      byte_nxt = byte_r;
      on_nxt = on_r;
      pend_nxt = 1'b0;
      bin_nxt = bin_r;
      page_mode_nxt = page_mode_r;
      mem_rd_en = 1'b0;
      if (start) begin
         on_nxt = 1'b1;
         bin_nxt = bin_s;
         page_mode_nxt = (opcode_r == `OP_READ_PAGE);
         if (bin_s) begin
            page_nxt = addr_in[`BIN_PAGE_MSB:`BIN_PAGE_LSB];
            byte_nxt = {1'b0, addr_in[`BIN_BYTE_MSB:0]};
         end else begin
            page_nxt = addr_in[`STD_PAGE_MSB:`STD_PAGE_LSB];
            byte_nxt = addr_in[`STD_BYTE_MSB:0];
         end
      end else if (cs_n_s) begin
         on_nxt = 1'b0;
      end else if (on_r && fill_s.ready && !pend_r) begin
         // One read in flight keeps the free-slot check exact
         mem_rd_en = 1'b1;
         pend_nxt = 1'b1;
         if (byte_r >= last_byte) begin
            byte_nxt = 9'h000;
            if (!page_mode_r) begin
               page_nxt = page_r + 9'h001;
            end
         end else begin
            byte_nxt = byte_r + 9'h001;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         page_r <= 9'h000;
         byte_r <= 9'h000;
         on_r <= 1'b0;
         pend_r <= 1'b0;
         bin_r <= 1'b0;
         page_mode_r <= 1'b0;
      end else begin
         page_r <= page_nxt;
         byte_r <= byte_nxt;
         on_r <= on_nxt;
         pend_r <= pend_nxt;
         bin_r <= bin_nxt;
         page_mode_r <= page_mode_nxt;
      end
   end

   // A read still in flight when select rises or a new command starts is
   // dropped here by the flush, so it can never leak into the next frame.
   // Array answers one cycle after the strobe; stale answers are dropped
   assign mem_page = page_r;
   assign mem_byte = byte_r;
   assign fill_s.valid = pend_r && !flush;
   assign fill_s.data = mem_rd_data;

endmodule : sflash_read

/* File: tb/array_model.sv */
// Behavioural main-memory array answering the read sequencer's array port
`timescale 1ns/1ps
module array_model (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic mem_rd_en, // Read strobe from the sequencer
   input wire sflash_read_pkg::page_t mem_page, // Page of the read
   input wire sflash_read_pkg::byte_t mem_byte, // Byte within the page
   output logic [7:0] mem_rd_data // Byte returned one cycle later
);
   // Data is valid only in the cycle after a strobe; otherwise it toggles,
   // so a late or early capture cannot match by luck
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_rd_data <= 8'h00;
      end else if (mem_rd_en) begin
         mem_rd_data <= mem_byte[7:0] + {mem_page[6:0], mem_byte[8]};
      end else begin
         mem_rd_data <= ~mem_rd_data;
      end
   end
endmodule : array_model

/* File: tb/sflash_read_asserts.sv */
// Concurrent checks on the ports of the read sequencer
`timescale 1ns/1ps
`include "sflash_read_map.svh"
module sflash_read_asserts (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Asynchronous reset
   input wire logic chip_select_n, // Host chip select
   input wire logic serial_clk, // Host serial clock
   input wire logic serial_in, // Host serial data
   input wire logic serial_out, // Serial data to host
   input wire logic serial_out_oe, // Output enable
   input wire logic page_size_bin, // Page layout select
   input wire logic mem_rd_en, // Array read strobe
   input wire sflash_read_pkg::page_t mem_page, // Array page
   input wire sflash_read_pkg::byte_t mem_byte, // Array byte
   input wire logic [7:0] mem_rd_data // Array data
);
   // ****************************************
   // Previous array address within one frame
   // ****************************************
   logic have_prev_r;
   sflash_read_pkg::page_t prev_page_r;
   sflash_read_pkg::byte_t prev_byte_r;
   logic last_w;
   // Cleared whenever chip select is high, so frames never chain
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         have_prev_r <= 1'b0;
         prev_page_r <= 9'h000;
         prev_byte_r <= 9'h000;
      end else if (chip_select_n) begin
         have_prev_r <= 1'b0;
      end else if (mem_rd_en) begin
         have_prev_r <= 1'b1;
         prev_page_r <= mem_page;
         prev_byte_r <= mem_byte;
      end
   end
   assign last_w = page_size_bin ? (prev_byte_r == `BIN_PAGE_LAST_BYTE) :
      (prev_byte_r == `STD_PAGE_LAST_BYTE);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // Sync lag allows a few cycles before the frame end is honoured
   sequence s_cs_gone;
      chip_select_n [*5];
   endsequence
   sequence s_step;
      mem_rd_en && have_prev_r;
   endsequence

   property p_oe_off;
      s_cs_gone |-> !serial_out_oe;
   endproperty
   property p_rd_stop;
      s_cs_gone |-> !mem_rd_en;
   endproperty
   property p_rd_gap;
      mem_rd_en |=> !mem_rd_en;
   endproperty
   property p_out_fall;
      serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !$past(serial_clk);
   endproperty
   property p_oe_rise;
      $rose(serial_out_oe) |-> $past(serial_clk, 2) && !chip_select_n;
   endproperty
   property p_std_range;
      mem_rd_en && !page_size_bin |-> mem_byte <= `STD_PAGE_LAST_BYTE;
   endproperty
   property p_bin_range;
      mem_rd_en && page_size_bin |-> mem_byte[8] == 1'b0;
   endproperty
   property p_seq_byte;
      s_step |-> mem_byte == (last_w ? 9'h000 : prev_byte_r + 9'h001);
   endproperty
   property p_seq_page;
      s_step ##0 !last_w |-> mem_page == prev_page_r;
   endproperty
   property p_seq_wrap;
      s_step ##0 last_w |-> mem_page == prev_page_r || mem_page == prev_page_r + 9'h001;
   endproperty

   a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");
   a_rd_stop: assert property (p_rd_stop) else $error("array read while deselected");
   a_rd_gap: assert property (p_rd_gap) else $error("array reads back to back");
   a_out_fall: assert property (p_out_fall) else $error("output moved off a fall");
   a_oe_rise: assert property (p_oe_rise) else $error("output enabled off a rise");
   a_std_range: assert property (p_std_range) else $error("byte beyond long page");
   a_bin_range: assert property (p_bin_range) else $error("byte beyond short page");
   a_seq_byte: assert property (p_seq_byte) else $error("byte counter skipped");
   a_seq_page: assert property (p_seq_page) else $error("page moved inside page");
   a_seq_wrap: assert property (p_seq_wrap) else $error("page jump at wrap");
endmodule : sflash_read_asserts

bind sflash_read sflash_read_asserts chk (.sys_clk(sys_clk), .rst(rst),
   .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
   .serial_out(serial_out), .serial_out_oe(serial_out_oe), .page_size_bin(page_size_bin),
   .mem_rd_en(mem_rd_en), .mem_page(mem_page), .mem_byte(mem_byte),
   .mem_rd_data(mem_rd_data));

/* File: tb/tb_top.sv */
// Self-checking testbench acting as host of the read sequencer
`timescale 1ns/1ps
`include "sflash_read_map.svh"
module tb_top;
   logic sys_clk, rst, chip_select_n, serial_clk, serial_in, page_size_bin;
   logic serial_out, serial_out_oe, mem_rd_en;
   sflash_read_pkg::page_t mem_page;
   sflash_read_pkg::byte_t mem_byte;
   logic [7:0] mem_rd_data;
   int err_count, n_tests;

   always #10 sys_clk = ~sys_clk;

   sflash_read dut (.sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n),
      .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .page_size_bin(page_size_bin), .mem_rd_en(mem_rd_en),
      .mem_page(mem_page), .mem_byte(mem_byte), .mem_rd_data(mem_rd_data));
   array_model u_array (.sys_clk(sys_clk), .rst(rst), .mem_rd_en(mem_rd_en),
      .mem_page(mem_page), .mem_byte(mem_byte), .mem_rd_data(mem_rd_data));

   // ****************************************
   // Host tasks
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   // One bit at 160 ns; returned data is taken just after the rising edge
   task automatic bit_x(input logic d, output logic q);
      @(posedge sys_clk);
      serial_clk <= 1'b0;
      serial_in <= d;
      repeat (4) @(posedge sys_clk);
      serial_clk <= 1'b1;
      #1 q = serial_out;
      repeat (3) @(posedge sys_clk);
   endtask : bit_x

   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
   endtask : xfer

   // Clock stands still at its idle level outside frames
   task automatic do_read(input logic [7:0] op, input int nd, input logic m3, input logic bin,
         input logic [8:0] pg, input logic [8:0] by, input int n, input int stall, input int part);
      logic [7:0] r;
      logic q;
      logic [23:0] a;
      logic [8:0] p;
      logic [8:0] b;
      a = bin ? {7'h00, pg, by[7:0]} : {6'h00, pg, by};
      p = pg;
      b = by;
      @(posedge sys_clk);
      serial_clk <= m3;
      page_size_bin <= bin;
      repeat (4) @(posedge sys_clk);
      chip_select_n <= 1'b0;
      xfer(op, r);
      for (int i = 2; i >= 0; i--) begin
         xfer(a[i*8 +: 8], r);
      end
      for (int i = 0; i < nd; i++) begin
         xfer(8'hA5, r);
      end
      for (int i = 0; i < n; i++) begin
         xfer(8'h00, r);
         check({8'h00, r}, {8'h00, b[7:0] + {p[6:0], b[8]}});
         if (b == (bin ? `BIN_PAGE_LAST_BYTE : `STD_PAGE_LAST_BYTE)) begin
            b = 9'h000;
            p = (op == `OP_READ_PAGE) ? p : p + 9'h001;
         end else begin
            b = b + 9'h001;
         end
         repeat ((i == 0) ? stall : 0) @(posedge sys_clk);
      end
      for (int i = 0; i < part; i++) begin
         bit_x(1'b1, q);
      end
      #1 check({15'h0000, serial_out_oe}, {15'h0000, n > 0});
      @(posedge sys_clk);
      serial_clk <= m3;
      chip_select_n <= 1'b1;
      serial_in <= ~serial_in;
      repeat (5) @(posedge sys_clk);
      #1 check({15'h0000, serial_out_oe}, 16'h0000);
      repeat (4) @(posedge sys_clk);
   endtask : do_read

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_continuous;
      do_read(`OP_READ_FAST, 1, 1'b0, 1'b0, 9'h005, 9'h105, 4, 0, 0);
      do_read(`OP_READ_LEGACY, 4, 1'b1, 1'b1, 9'h1FF, 9'h0FE, 4, 0, 0);
      do_read(`OP_READ_SLOW, 0, 1'b0, 1'b0, 9'h1FF, 9'h106, 3, 0, 0);
      do_read(`OP_READ_SLOW, 0, 1'b1, 1'b1, 9'h0A0, 9'h0FF, 2, 0, 0);
      $display("continuous reads across page and array ends done");
   endtask : t_continuous

   // Long short-page read with a stall fills the buffer and wraps within the page
   task automatic t_page;
      do_read(`OP_READ_PAGE, 4, 1'b1, 1'b0, 9'h007, 9'h106, 4, 0, 0);
      do_read(`OP_READ_PAGE, 4, 1'b0, 1'b1, 9'h003, 9'h0FA, 264, 100, 0);
      $display("page reads with wrap and stall done");
   endtask : t_page

   // Abort mid-byte; the next frame must not see stale prefetched bytes
   task automatic t_abort;
      do_read(`OP_READ_LEGACY, 4, 1'b0, 1'b1, 9'h010, 9'h020, 2, 0, 3);
      do_read(`OP_READ_FAST, 1, 1'b0, 1'b1, 9'h010, 9'h040, 2, 0, 0);
      do_read(8'h84, 2, 1'b0, 1'b0, 9'h001, 9'h000, 0, 0, 0);
      $display("abort and unsupported opcode done");
   endtask : t_abort

   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      chip_select_n = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
      page_size_bin = 1'b0;
      err_count = 0;
      n_tests = 0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_continuous();
      t_page();
      t_abort();
      final_report();
   end

   // Hang guard counts as a mismatch
   initial begin
      repeat (100000) @(posedge sys_clk);
      check(16'h0000, 16'h0001);
      final_report();
   end
endmodule : tb_top
